// File: core/isdx_exec.v
// Execute unit for increment/decrement-skip, absolute jump and inclusive OR
// Takes one instruction word at each rising edge while instr_valid is high
// Assumes the core supplies the fetched word, file read data and the latch value
// Assumes file read data belongs to the address in the offered word, same cycle
// Assumes the core writes file_wdata_ff back when file_we_ff pulses
`timescale 1ns/1ps
`include "isdx_regs.vh"
module isdx_exec (
  input wire clk,
  input wire rst_n,
  input wire instr_valid,
  input wire [13:0] instr,
  input wire [7:0] file_rdata,
  input wire [7:0] upper_address_latch,
  output reg [7:0] acc_ff,
  output reg zero_flag_ff,
  output reg [14:0] pc_ff,
  output reg file_we_ff,
  output reg [6:0] file_waddr_ff,
  output reg [7:0] file_wdata_ff,
  output reg nop_slot_ff,
  output reg busy_ff
);

  // Slot states: run executes the offered word, drop turns it into a no-operation
  localparam SLOT_RUN = 1'b0;
  localparam SLOT_DROP = 1'b1;

  // Next values of the registered outputs
  reg [7:0] nxt_acc;
  reg nxt_zero;
  reg [14:0] nxt_pc;
  reg nxt_we;
  reg [6:0] nxt_waddr;
  reg [7:0] nxt_wdata;
  reg nxt_nop;

  // Result of the word in this cycle, before routing
  reg [7:0] res;
  wire res_zero;

  // Fields of the offered word
  wire [5:0] op6;
  wire [2:0] op3;
  wire dbit;
  wire [6:0] faddr;
  wire [7:0] lit8;
  wire [10:0] lit11;

  // Decoded instruction kinds
  wire is_jump;
  wire is_dec_skip;
  wire is_inc_skip;
  wire is_inc_file;
  wire is_or_file;
  wire is_or_lit;
  wire is_skip_kind;
  wire is_zero_kind;
  wire routes_dest;
  wire live;

  // Zero detect shared by every flag update and both skip tests
  function isdx_is_zero;
    input [7:0] v;
    begin
      isdx_is_zero = (v == 8'h00);
    end
  endfunction

  // Eight-bit step up or down; wraps at both ends as the core expects
  function [7:0] isdx_step;
    input [7:0] v;
    input down;
    begin
      if (down) begin
        isdx_step = v - 8'h01;
      end else begin
        isdx_step = v + 8'h01;
      end
    end
  endfunction

  // Inclusive OR of the accumulator with a second operand
  function [7:0] isdx_or8;
    input [7:0] a;
    input [7:0] b;
    begin
      isdx_or8 = a | b;
    end
  endfunction

  // Jump target: latch bits six to three above the eleven-bit literal
  function [14:0] isdx_jump_target;
    input [7:0] latch;
    input [10:0] k;
    begin
      isdx_jump_target = {latch[`ISDX_LATCH_HI:`ISDX_LATCH_LO], k};
    end
  endfunction

  // Field split of the fourteen-bit word
  assign op6 = instr[`ISDX_OP6_HI:`ISDX_OP6_LO];
  assign op3 = instr[`ISDX_OP6_HI:`ISDX_OP3_LO];
  assign dbit = instr[`ISDX_DEST_BIT];
  assign faddr = instr[6:0];
  assign lit8 = instr[7:0];
  assign lit11 = instr[10:0];

  // Opcode decode; codes not listed here only advance the counter
  assign is_jump = (op3 == `ISDX_OP_JUMP);
  assign is_dec_skip = (op6 == `ISDX_OP_DEC_SKIP);
  assign is_inc_skip = (op6 == `ISDX_OP_INC_SKIP);
  assign is_inc_file = (op6 == `ISDX_OP_INC_FILE);
  assign is_or_file = (op6 == `ISDX_OP_OR_FILE);
  assign is_or_lit = (op6 == `ISDX_OP_OR_LIT);

  // Groups: skip kinds test the result, zero kinds move the flag
  assign is_skip_kind = is_dec_skip || is_inc_skip;
  assign is_zero_kind = is_inc_file || is_or_file || is_or_lit;
  assign routes_dest = is_skip_kind || is_inc_file || is_or_file;

  // A word offered in a drop slot is swallowed, so it must never execute
  assign live = instr_valid && (nop_slot_ff == SLOT_RUN);

  // Arithmetic and logic result of the offered word
  always @* begin
    res = 8'h00;
    if (is_dec_skip) begin
      res = isdx_step(file_rdata, 1'b1);
    end else if (is_inc_skip) begin
      res = isdx_step(file_rdata, 1'b0);
    end else if (is_inc_file) begin
      res = isdx_step(file_rdata, 1'b0);
    end else if (is_or_file) begin
      res = isdx_or8(acc_ff, file_rdata);
    end else if (is_or_lit) begin
      res = isdx_or8(acc_ff, lit8);
    end
  end

  // Zero test of the result, used by the flag and by the skip decision
  assign res_zero = isdx_is_zero(res);

  // Destination routing: accumulator or a write back to the file register
  always @* begin
    nxt_acc = acc_ff;
    nxt_we = 1'b0;
    nxt_waddr = file_waddr_ff;
    nxt_wdata = file_wdata_ff;
    if (live) begin
      if (is_or_lit) begin
        nxt_acc = res;
      end else if (routes_dest) begin
        if (dbit == `ISDX_DEST_ACC) begin
          nxt_acc = res;
        end else begin
          nxt_we = 1'b1;
          nxt_waddr = faddr;
          nxt_wdata = res;
        end
      end
    end
  end

  // Zero flag: only the plain increment and the two OR forms touch it
  always @* begin
    nxt_zero = zero_flag_ff;
    if (live && is_zero_kind) begin
      nxt_zero = res_zero;
    end
  end

  // Program counter: one step per offered word, jump loads the target
  always @* begin
    nxt_pc = pc_ff;
    if (instr_valid) begin
      if (live && is_jump) begin
        nxt_pc = isdx_jump_target(upper_address_latch, lit11);
      end else begin
        nxt_pc = pc_ff + 15'h0001;
      end
    end
  end

  // Slot control: a jump or a taken skip turns the next word into a no-operation
  always @* begin
    nxt_nop = SLOT_RUN;
    case (nop_slot_ff)
      SLOT_RUN: begin
        if (live && is_jump) begin
          nxt_nop = SLOT_DROP;
        end else if (live && is_skip_kind && res_zero) begin
          nxt_nop = SLOT_DROP;
        end else begin
          nxt_nop = SLOT_RUN;
        end
      end
      SLOT_DROP: begin
        // The slot waits for a word, so an idle cycle keeps it pending
        if (instr_valid) begin
          nxt_nop = SLOT_RUN;
        end else begin
          nxt_nop = SLOT_DROP;
        end
      end
      default: begin
        nxt_nop = SLOT_RUN;
      end
    endcase
  end

  // Accumulator register
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff <= `ISDX_W_RST;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  // Zero flag register
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      zero_flag_ff <= `ISDX_Z_RST;
    end else begin
      zero_flag_ff <= nxt_zero;
    end
  end

  // Program counter register
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_ff <= `ISDX_PC_RST;
    end else begin
      pc_ff <= nxt_pc;
    end
  end

  // File write port; the strobe lasts one cycle, address and data hold after
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      file_we_ff <= 1'b0;
      file_waddr_ff <= `ISDX_WADDR_RST;
      file_wdata_ff <= `ISDX_WDATA_RST;
    end else begin
      file_we_ff <= nxt_we;
      file_waddr_ff <= nxt_waddr;
      file_wdata_ff <= nxt_wdata;
    end
  end

  // Slot state and its busy copy for the fetch side
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nop_slot_ff <= SLOT_RUN;
      busy_ff <= 1'b0;
    end else begin
      nop_slot_ff <= nxt_nop;
      busy_ff <= nxt_nop;
    end
  end
endmodule // isdx_exec

// File: core/isdx_regs.vh
// Constants for the inc/dec/skip/jump/or execute unit
// Assumes a 14-bit instruction word and one instruction offered per cycle
// Functional notes
// - Decrement-and-skip subtracts one from file register 0..127, result to destination.
// - Destination bit 0 writes accumulator, 1 writes back to file register.
// - Decrement-and-skip zero result turns next instruction into a no-operation.
// - Increment-and-skip adds one, routes result, zero result skips next instruction.
// - Absolute jump loads 11-bit literal into counter bits ten to zero.
// - Counter bits fourteen to eleven come from upper-address latch bits six to three.
// - Absolute jump takes two cycles and leaves all flags alone.
// - Plain increment adds one, routes by destination bit, updates zero flag.
// - OR-literal ORs accumulator with 8-bit immediate into accumulator, updates zero.
// - OR-with-file ORs accumulator with file register, routes result, updates zero.
`ifndef ISDX_REGS_VH
`define ISDX_REGS_VH
`define ISDX_OP_DEC_SKIP 6'h0B
`define ISDX_OP_INC_SKIP 6'h0F
`define ISDX_OP_INC_FILE 6'h0A
`define ISDX_OP_OR_LIT 6'h38
`define ISDX_OP_OR_FILE 6'h04
`define ISDX_OP_JUMP 3'h5
`define ISDX_DEST_ACC 1'h0
`define ISDX_W_RST 8'h00
`define ISDX_Z_RST 1'h0
`define ISDX_PC_RST 15'h0000
`define ISDX_WADDR_RST 7'h00
`define ISDX_WDATA_RST 8'h00
`define ISDX_OP6_HI 13
`define ISDX_OP6_LO 8
`define ISDX_OP3_LO 11
`define ISDX_DEST_BIT 7
`define ISDX_JUMP_CYCLES 2
`define ISDX_LATCH_HI 6
`define ISDX_LATCH_LO 3
`endif

// File: tb/isdx_checker.sv
// Port checker for the execute unit
// Assumes it sees the top module's ports only
`timescale 1ns/1ps
module isdx_chk (input wire clk, rst_n, instr_valid, zero_flag_ff, file_we_ff, nop_slot_ff,
  busy_ff, input wire [13:0] instr, input wire [7:0] file_rdata, upper_address_latch, acc_ff,
  file_wdata_ff, input wire [14:0] pc_ff, input wire [6:0] file_waddr_ff);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Word executed at this edge, and its opcode
  wire ex = instr_valid && !nop_slot_ff;
  wire [5:0] op = instr[13:8];
  AST_DEC: assert property (ex && op == 6'h0B && instr[7] |=> file_we_ff &&
    file_wdata_ff == $past(file_rdata) - 8'h01) else $error("dec");
  AST_INC: assert property (ex && op == 6'h0A && !instr[7] |=> !file_we_ff &&
    acc_ff == $past(file_rdata) + 8'h01) else $error("inc");
  AST_SKP: assert property (ex && op == 6'h0B && file_rdata == 8'h01 |=> nop_slot_ff)
    else $error("skp");
  AST_ISK: assert property (ex && op == 6'h0F |=> $stable(zero_flag_ff) &&
    nop_slot_ff == ($past(file_rdata) == 8'hFF)) else $error("isk");
  AST_JMP: assert property (ex && instr[13:11] == 3'h5 |=>
    pc_ff == {$past(upper_address_latch[6:3]), $past(instr[10:0])}) else $error("jmp");
  AST_JZ: assert property (ex && instr[13:11] == 3'h5 |=> nop_slot_ff &&
    $stable(zero_flag_ff) ##1 $stable(zero_flag_ff)) else $error("jz");
  AST_ORL: assert property (ex && op == 6'h38 |=> acc_ff == ($past(acc_ff) |
    $past(instr[7:0])) && zero_flag_ff == (acc_ff == 8'h00)) else $error("orl");
  AST_ORF: assert property (ex && op == 6'h04 && instr[7] |=> zero_flag_ff ==
    !file_wdata_ff && file_wdata_ff == ($past(acc_ff) | $past(file_rdata))) else $error("orf");
  AST_BSY: assert property (busy_ff == nop_slot_ff) else $error("bsy");
  AST_WAD: assert property (ex && op == 6'h0B && instr[7] |=>
    file_waddr_ff == $past(instr[6:0])) else $error("wad");
  // Main scenarios reached
  C_JMP: cover property (ex && instr[13:11] == 3'h5);
  C_DRP: cover property (instr_valid && nop_slot_ff);
  C_ORL: cover property (ex && op == 6'h38);
endmodule // isdx_chk
bind isdx_exec isdx_chk u_chk (.clk, .rst_n, .instr_valid, .zero_flag_ff, .file_we_ff,
  .nop_slot_ff, .busy_ff, .instr, .file_rdata, .upper_address_latch, .acc_ff, .file_wdata_ff,
  .pc_ff, .file_waddr_ff);

// File: tb/test_incdec_skip_jump_or_exec.sv
// Directed self-checking bench for the execute unit
// Assumes one word taken per rising edge while valid is high
`timescale 1ns/1ps
module test_incdec_skip_jump_or_exec;
  logic clk = 0, rst_n = 0, instr_valid = 0, zero_flag_ff, file_we_ff, nop_slot_ff, busy_ff;
  logic [13:0] instr = 14'h0000;
  logic [7:0] file_rdata = 8'h00, upper_address_latch = 8'h78, acc_ff, file_wdata_ff;
  logic [14:0] pc_ff;
  logic [6:0] file_waddr_ff;
  int error_cnt = 0, n_tests = 0;
  isdx_exec dut (.clk, .rst_n, .instr_valid, .instr, .file_rdata, .upper_address_latch,
    .acc_ff, .zero_flag_ff, .pc_ff, .file_we_ff, .file_waddr_ff, .file_wdata_ff,
    .nop_slot_ff, .busy_ff);
  // Clock and watchdog
  initial forever #12.5 clk = ~clk;
  initial begin
    #20us;
    error_cnt++;
    report_and_stop();
  end
  // Offer one word for one rising edge
  task automatic issue(input logic [13:0] w, input logic [7:0] f);
    @(negedge clk) instr_valid = 1'h1;
    instr = w;
    file_rdata = f;
    @(negedge clk) instr_valid = 1'h0;
  endtask
  // Compare one result
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic t_or_inc;
    issue(14'h3800, 8'h00);
    chk(zero_flag_ff, 16'h0001);
    issue(14'h385A, 8'h00);
    chk(acc_ff, 16'h005A);
    issue(14'h04A5, 8'h81);
    chk({file_we_ff, file_wdata_ff}, 16'h01DB);
    issue(14'h0A10, 8'hFF);
    chk({file_we_ff, zero_flag_ff, acc_ff}, 16'h0100);
    $display("or and increment done");
  endtask
  task automatic t_skip_jump;
    issue(14'h0BFF, 8'h01);
    chk({nop_slot_ff, file_waddr_ff, file_wdata_ff}, 16'hFF00);
    issue(14'h38FF, 8'h00);
    chk({nop_slot_ff, acc_ff}, 16'h0000);
    issue(14'h0F05, 8'hFF);
    chk({nop_slot_ff, zero_flag_ff, acc_ff}, 16'h0300);
    issue(14'h0000, 8'h00);
    issue(14'h2FFF, 8'h00);
    chk({zero_flag_ff, pc_ff}, 16'hFFFF);
    chk({nop_slot_ff, busy_ff}, 16'h0003);
    issue(14'h385A, 8'h00);
    chk({nop_slot_ff, busy_ff, acc_ff, zero_flag_ff}, 16'h0001);
    chk(pc_ff, 16'h0000);
    $display("skip and jump done");
  endtask
  // Closing verdict
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'h1;
    t_or_inc();
    t_skip_jump();
    report_and_stop();
  end
endmodule // test_incdec_skip_jump_or_exec
